// File: mscat_defines.vh
// Register offsets, field layouts and reset values of the scanner address/trigger block
`ifndef MSCAT_DEFINES_VH
`define MSCAT_DEFINES_VH
`define MSCAT_OFF_START_HIGH  3'h0
`define MSCAT_OFF_START_LOW   3'h1
`define MSCAT_OFF_END_HIGH    3'h2
`define MSCAT_OFF_END_LOW     3'h3
`define MSCAT_OFF_TRIG_SEL    3'h4
`define MSCAT_OFF_STATUS      3'h5
`define MSCAT_ADDR_RESET      16'h0000
`define MSCAT_TRIGGER_SOURCE_SELECT_RESET      4'h0
`define MSCAT_TRIGGER_SOURCE_SELECT_MAX        4'h9
`define MSCAT_STAT_DONE_BIT   0
`define MSCAT_STAT_GO_BIT     1
`endif

// File: mscat_trig_mux.v
// Trigger source selector for scanner fetches
`include "mscat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mscat_trig_mux (
  // Selection
  input  wire [3:0] trigger_source_select,
  // Synchronised sources, index equals select code
  input  wire [9:0] sources,
  // Chosen trigger level
  output reg        trig_level
);
  always @* begin
    if (trigger_source_select <= `MSCAT_TRIGGER_SOURCE_SELECT_MAX) begin
      trig_level = sources[trigger_source_select];
    end else begin
      trig_level = 1'b0; // Reserved codes never trigger
    end
  end
endmodule // mscat_trig_mux
`default_nettype wire

// File: mscat_core.v
// Scanner address range registers, trigger selection and fetch sequencing
//
// Implementation choices: strobed register access and the address map.
`include "mscat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mscat_core (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register port
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Scan control from outside
  input  wire        scan_go_a,
  // Asynchronous trigger sources
  input  wire        low_freq_internal_osc,
  input  wire        timer_two,
  input  wire        timer_four,
  input  wire        timer_six,
  input  wire        timer_one,
  input  wire        timer_three,
  input  wire        timer_five,
  input  wire        timer_zero,
  input  wire        measure_timer_one,
  input  wire        measure_timer_two,
  // Memory fetch handshake
  output wire        fetch_req,
  output reg  [15:0] fetch_addr,
  input  wire        fetch_ack,
  // Scan status
  output reg         scan_done
);
  // ==========================================================
  // Source synchronisers
  wire [9:0] src_raw = {measure_timer_two, measure_timer_one, timer_zero, timer_five,
                        timer_three, timer_one,
                        timer_six, timer_four, timer_two, low_freq_internal_osc};
  reg  [9:0] src_meta_reg;
  reg  [9:0] src_sync_reg;
  reg        go_meta_reg;
  reg        go_sync_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_meta_reg <= 10'h000;
      src_sync_reg <= 10'h000;
      go_meta_reg  <= 1'b0;
      go_sync_reg  <= 1'b0;
    end else begin
      src_meta_reg <= src_raw;
      src_sync_reg <= src_meta_reg;
      go_meta_reg  <= scan_go_a;
      go_sync_reg  <= go_meta_reg;
    end
  end

  // ==========================================================
  // Registers
  reg [15:0] start_current_address_reg;
  reg [15:0] end_address_reg;
  reg [3:0]  trigger_source_select_reg;
  reg        pending_reg;
  reg        trig_prev_reg;
  wire       trig_level;
  wire       trig_rise = trig_level & ~trig_prev_reg;
  wire       fetch_done = pending_reg & fetch_ack;
  wire       last_word = (start_current_address_reg == end_address_reg);
  wire       wr_ok = reg_wr & ~go_sync_reg;

  assign fetch_req = pending_reg;

  mscat_trig_mux u_trig_mux (
    .trigger_source_select (trigger_source_select_reg),
    .sources               (src_sync_reg),
    .trig_level            (trig_level)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_current_address_reg <= `MSCAT_ADDR_RESET;
      end_address_reg           <= `MSCAT_ADDR_RESET;
      trigger_source_select_reg <= `MSCAT_TRIGGER_SOURCE_SELECT_RESET;
      pending_reg               <= 1'b0;
      trig_prev_reg             <= 1'b0;
      scan_done                 <= 1'b0;
      fetch_addr                <= 16'h0000;
    end else begin
      trig_prev_reg <= trig_level;
      if (wr_ok) begin
        case (reg_addr)
          `MSCAT_OFF_START_HIGH: begin
            start_current_address_reg[15:8] <= reg_wdata;
            scan_done <= 1'b0;
          end
          `MSCAT_OFF_START_LOW: begin
            start_current_address_reg[7:0] <= reg_wdata;
            scan_done <= 1'b0;
          end
          `MSCAT_OFF_END_HIGH: begin
            end_address_reg[15:8] <= reg_wdata;
          end
          `MSCAT_OFF_END_LOW: begin
            end_address_reg[7:0] <= reg_wdata;
          end
          `MSCAT_OFF_TRIG_SEL: begin
            trigger_source_select_reg <= reg_wdata[3:0];
          end
          default: begin
          end
        endcase
      end
      // Issue a fetch on a rising trigger edge while running, not done and with no fetch pending
      if (go_sync_reg && !scan_done && !pending_reg && trig_rise) begin
        pending_reg <= 1'b1;
        fetch_addr  <= start_current_address_reg;
      end else if (fetch_done) begin
        pending_reg <= 1'b0;
        if (last_word) begin
          scan_done <= 1'b1;
        end else begin
          start_current_address_reg <= start_current_address_reg + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // Read port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MSCAT_OFF_START_HIGH: reg_rdata <= start_current_address_reg[15:8];
        `MSCAT_OFF_START_LOW:  reg_rdata <= start_current_address_reg[7:0];
        `MSCAT_OFF_END_HIGH:   reg_rdata <= end_address_reg[15:8];
        `MSCAT_OFF_END_LOW:    reg_rdata <= end_address_reg[7:0];
        `MSCAT_OFF_TRIG_SEL:   reg_rdata <= {4'h0, trigger_source_select_reg};
        `MSCAT_OFF_STATUS:     reg_rdata <= {6'h00, go_sync_reg, scan_done};
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // mscat_core
`default_nettype wire

// File: mscat_props.sv
// Checker of the scanner register and fetch ports
`timescale 1ns/1ps
`default_nettype none
module mscat_props (
  // Clock, strobes and fetch handshake
  input wire logic        clk, rst_n, reg_wr, reg_rd, fetch_req, fetch_ack, scan_done,
  // Buses
  input wire logic [2:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] fetch_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] nxt_q;
  logic        nxt_v;
  // Next expected fetch address, forgotten on a start write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) nxt_v <= 1'b0;
    else if (reg_wr && reg_addr < 3'h2) nxt_v <= 1'b0;
    else if (fetch_req && fetch_ack) nxt_v <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (fetch_req && fetch_ack) nxt_q <= fetch_addr + 16'h1;
  end
  req_hold_a:
    assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr)) else $error("req");
  addr_step_a:
    assert property ($rose(fetch_req) && nxt_v |-> fetch_addr == nxt_q) else $error("step");
  ack_drop_a:
    assert property (fetch_req && fetch_ack |=> !fetch_req) else $error("drop");
  done_stop_a:
    assert property (scan_done |-> !fetch_req) else $error("stop");
  done_hold_a:
    assert property (scan_done && !(reg_wr && reg_addr < 3'h2) |=> scan_done) else $error("hold");
  done_read_a:
    assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata[0] == $past(scan_done)) else $error("st");
  trig_top_a:
    assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:4] == 4'h0) else $error("top");
  rd_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("idle");
  cover property (fetch_req && fetch_ack);
  cover property (scan_done);
  cover property (reg_rd && reg_addr == 3'h4);
endmodule // mscat_props
bind mscat_core mscat_props i_props (.clk, .rst_n, .reg_wr, .reg_rd, .fetch_req, .fetch_ack,
  .scan_done, .reg_addr, .reg_rdata, .fetch_addr);
`default_nettype wire

// File: mscat_mem_model.sv
// Memory side model acknowledging scanner fetches after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module mscat_mem_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       fetch_req,
  input wire logic [1:0] slow,
  output logic           fetch_ack
);
  logic [1:0] wait_q;
  // One ack pulse per request, after slow idle cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack <= 1'b0;
      wait_q    <= 2'h0;
    end else begin
      fetch_ack <= fetch_req && !fetch_ack && wait_q == slow;
      wait_q    <= (fetch_req && !fetch_ack && wait_q != slow) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule // mscat_mem_model
`default_nettype wire

// File: memory_scanner_address_trigger_test.sv
// Self-checking bench of the scanner address and trigger block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: %h %h", $time, g, e); end end
module memory_scanner_address_trigger_test;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, ack, req, done;
  logic [2:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata;
  logic [9:0]  src = 0;
  logic [1:0]  slow = 0;
  logic [15:0] faddr, ea = 16'h1234;
  int          n_fail = 0, n_tests = 0, nf = 0, b;
  initial forever #25 clk = ~clk;
  mscat_core i_dut (.clk, .rst_n, .reg_addr(addr), .reg_wdata(wdata), .reg_wr, .reg_rd,
    .reg_rdata(rdata), .scan_go_a(go), .low_freq_internal_osc(src[0]), .timer_two(src[1]),
    .timer_four(src[2]), .timer_six(src[3]), .timer_one(src[4]), .timer_three(src[5]),
    .timer_five(src[6]), .timer_zero(src[7]), .measure_timer_one(src[8]),
    .measure_timer_two(src[9]), .fetch_req(req), .fetch_addr(faddr), .fetch_ack(ack), .scan_done(done));
  mscat_mem_model i_mem (.clk, .rst_n, .fetch_req(req), .slow, .fetch_ack(ack));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; reg_wr <= 1'b1; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; reg_rd <= 1'b1; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic setgo(input logic g);
    @(posedge clk) go <= g;
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk) src <= v;
    repeat (5) @(posedge clk);
    src <= 10'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Every completed fetch must carry the next address
  always @(posedge clk) if (req === 1'b1 && ack === 1'b1) begin
    `CHK(faddr, ea)
    ea <= ea + 16'h1;
    nf++;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    wr(3'h2, 8'h12);
    wr(3'h3, 8'h3d);
    for (int k = 0; k < 16; k++) begin
      wr(3'h4, 8'hf0 | k[7:0]);
      rd(3'h4, {4'h0, k[3:0]});
      slow <= k[1:0];
      setgo(1'b1);
      b = nf;
      pulse(k < 10 ? ~(10'h1 << k) : 10'h3ff);
      `CHK(nf, b)
      if (k < 10) pulse(10'h1 << k);
      `CHK(nf, b + (k < 10))
      if (k == 0) wr(3'h0, 8'hff);
      if (k == 0) wr(3'h3, 8'h00);
      setgo(1'b0);
    end
    #1 `CHK(done, 1'b1)
    rd(3'h0, 8'h12);
    rd(3'h2, 8'h12);
    rd(3'h1, 8'h3d);
    rd(3'h3, 8'h3d);
    rd(3'h5, 8'h01);
    wr(3'h4, 8'h00);
    setgo(1'b1);
    pulse(10'h001);
    `CHK(nf, 10)
    setgo(1'b0);
    wr(3'h1, 8'h00);
    #1 `CHK(done, 1'b0)
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    rd(3'h2, 8'h00);
    give_verdict;
  end
  initial begin
    #200000;
    n_fail++;
    give_verdict;
  end
endmodule // memory_scanner_address_trigger_test
`default_nettype wire
